// ===== dec_pkg.sv
// package: constants, field layouts and carrier types of the debounced event counter
package dec_pkg;

    // ==========================================================
    // clock and debounce timing
    localparam int CLK_MHZ = 250;
    localparam int DBNC_TICK_NS = 500;
    // debounce base tick; 500 ns at 250 MHz is 125 cycles
    localparam int DBNC_TICK_CYC = (DBNC_TICK_NS * CLK_MHZ + 999) / 1000;
    localparam int DBNC_CODES = 16;
    // selectable stability times, shortest 500 ns, longest 25.5 ms
    localparam int DBNC_TIME_NS [DBNC_CODES] = '{500, 1000, 2000, 5000, 10000, 20000, 50000, 100000,
        200000, 500000, 1000000, 2000000, 5000000, 10000000, 20000000, 25500000};
    localparam int TICK_CNT_W = 12;
    localparam int STAB_W = 16;
    localparam logic [STAB_W-1:0] STAB_MAX = 16'hFFFF;

    // ==========================================================
    // sizes
    localparam int NUM_CH = 4;
    localparam int CNT_W = 32;
    localparam int HALF_W = 16;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [CNT_W-1:0] TOP16 = 32'h0000FFFF;
    localparam logic [CNT_W-1:0] TOP32 = 32'hFFFFFFFF;

    // ==========================================================
    // register map: address = {channel, register}
    localparam int CH_LSB = 3;
    localparam logic [2:0] REG_CFG_CNT = 3'h0;
    localparam logic [2:0] REG_CFG_IN = 3'h1;
    localparam logic [2:0] REG_ASYNC_LO = 3'h2;
    localparam logic [2:0] REG_ASYNC_HI = 3'h3;
    localparam logic [2:0] REG_HOLD_LO = 3'h4;
    localparam logic [2:0] REG_HOLD_HI = 3'h5;

    // ==========================================================
    // modes and carrier types
    typedef enum logic [1:0] {MODE_TOTAL, MODE_CLR_RD, MODE_STOP_TOP} dec_mode_e;
    typedef enum logic [1:0] {DBM_BYPASS, DBM_AFTER, DBM_BEFORE} dec_dbm_e;

    // counter configuration, bits [7:0] of REG_CFG_CNT
    typedef struct packed {
        logic [1:0] map_sel;
        logic dec_en;
        logic gate_en;
        logic latch_map;
        logic wide;
        dec_mode_e mode;
    } dec_ccfg_s;

    // input configuration, bits [6:0] of REG_CFG_IN
    typedef struct packed {
        logic [3:0] code;
        dec_dbm_e dbm;
        logic inv;
    } dec_icfg_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dec_bus_s;

    typedef struct packed {
        logic req;
        logic [1:0] ch;
        logic full;
        logic hi;
    } dec_smp_s;

    localparam dec_ccfg_s CCFG_RST = 8'h00;
    localparam dec_icfg_s ICFG_RST = 7'h00;

endpackage

// ===== dec_debounce.sv
// debounce stage of one counter input: synchroniser, inverter, two debounce modes and bypass
`timescale 1ns/1ps
module dec_debounce
    import dec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin_raw,
    input wire logic tick,
    input wire dec_icfg_s icfg,
    output logic db_out
);

    // ==========================================================
    // pin synchroniser: a change counts once stages two and three agree
    logic sy1_ff;
    logic sy2_ff;
    logic sy3_ff;
    logic flt_ff;
    logic prv_ff;
    logic out_ff;
    logic [STAB_W-1:0] stab_ff;

    wire logic lvl = flt_ff ^ icfg.inv;
    wire logic chg = lvl != prv_ff;
    wire logic [STAB_W-1:0] tgt = STAB_W'(DBNC_TIME_NS[icfg.code] / DBNC_TICK_NS);
    // strictly greater: the first tick after a change may come at once
    wire logic stable = stab_ff > tgt;
    wire logic [STAB_W-1:0] nxt_stab = chg ? '0 : ((tick && stab_ff != STAB_MAX) ? stab_ff + 1'b1 : stab_ff);

    logic nxt_out;
    always_comb
    begin
        nxt_out = out_ff;
        case (icfg.dbm)
            DBM_BYPASS: nxt_out = lvl;
            DBM_AFTER:
            begin
                if (!chg && stable && lvl != out_ff)
                    nxt_out = lvl;
            end
            DBM_BEFORE:
            begin
                if (chg && stable)
                    nxt_out = lvl;
                else if (!chg && stable && lvl != out_ff)
                    nxt_out = lvl;
            end
            default: nxt_out = lvl;
        endcase
    end

    // bypass takes the inverter output straight through, ignoring the time code
    assign db_out = (icfg.dbm == DBM_BYPASS) ? lvl : out_ff;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sy1_ff <= 1'b0;
            sy2_ff <= 1'b0;
            sy3_ff <= 1'b0;
            flt_ff <= 1'b0;
            prv_ff <= 1'b0;
            out_ff <= 1'b0;
            stab_ff <= '0;
        end
        else
        begin
            sy1_ff <= pin_raw;
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            if (sy2_ff == sy3_ff)
                flt_ff <= sy3_ff;
            prv_ff <= lvl;
            out_ff <= nxt_out;
            stab_ff <= nxt_stab;
        end
    end

endmodule

// ===== dec_event_counter.sv
// top: four debounced 32-bit event counters with register port and scan sample port
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dec_event_counter
    import dec_pkg::*;
#(
    parameter int DBNC_TICK_CYC_P = DBNC_TICK_CYC
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NUM_CH-1:0] cnt_pin,
    input wire logic scan_begin,
    input wire logic scan_tick,
    input wire dec_bus_s bus,
    output logic [DATA_W-1:0] rd_data,
    input wire dec_smp_s smp,
    output logic [DATA_W-1:0] smp_data,
    output logic smp_vld,
    output logic smp_word_hi
);

    // ==========================================================
    // debounce base tick
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(DBNC_TICK_CYC_P - 1);

    logic [TICK_CNT_W-1:0] tick_ff;
    wire logic tick = tick_ff == TICK_LAST;
    wire logic [TICK_CNT_W-1:0] nxt_tick = tick ? '0 : tick_ff + 1'b1;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            tick_ff <= '0;
        else
            tick_ff <= nxt_tick;
    end

    // ==========================================================
    // register port decode
    wire logic [1:0] sel_ch = bus.addr[CH_LSB+1:CH_LSB];
    wire logic [2:0] sel_reg = bus.addr[CH_LSB-1:0];
    wire logic wr_ccfg = bus.wr && sel_reg == REG_CFG_CNT;
    wire logic wr_icfg = bus.wr && sel_reg == REG_CFG_IN;
    wire logic rd_alo = bus.rd && sel_reg == REG_ASYNC_LO;

    // ==========================================================
    // per-channel state, gathered for the read and sample muxes
    dec_ccfg_s ccfg_v [NUM_CH];
    dec_icfg_s icfg_v [NUM_CH];
    logic [CNT_W-1:0] cnt_v [NUM_CH];
    logic [CNT_W-1:0] ahold_v [NUM_CH];
    logic [CNT_W-1:0] shold_v [NUM_CH];
    logic [NUM_CH-1:0] db;
    logic [NUM_CH-1:0] db_prv_ff;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            db_prv_ff <= '0;
        else
            db_prv_ff <= db;
    end

    // rising edge after the inverter is the counted edge
    wire logic [NUM_CH-1:0] db_rise = db & ~db_prv_ff;

    // ==========================================================
    // channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            localparam logic [1:0] OWN_IDX = 2'(gi);

            dec_ccfg_s ccfg_ff;
            dec_icfg_s icfg_ff;
            logic [CNT_W-1:0] cnt_ff;
            logic [CNT_W-1:0] ahold_ff;
            logic [CNT_W-1:0] shold_ff;

            dec_debounce u_dbnc
            (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .pin_raw(cnt_pin[gi]),
                .tick(tick),
                .icfg(icfg_ff),
                .db_out(db[gi])
            );

            wire logic own = ccfg_ff.map_sel == OWN_IDX;
            wire logic map_lvl = db[ccfg_ff.map_sel];
            wire logic map_rise = db_rise[ccfg_ff.map_sel] && !own;
            // inverted auxiliary input flips the gate sense through its own inverter
            wire logic gate_ok = !ccfg_ff.gate_en || own || map_lvl;
            wire logic [CNT_W-1:0] top = ccfg_ff.wide ? TOP32 : TOP16;
            wire logic at_top = ccfg_ff.mode == MODE_STOP_TOP && cnt_ff >= top;
            wire logic up = db_rise[gi] && gate_ok && !at_top;
            wire logic dn = ccfg_ff.dec_en && map_rise;
            wire logic rd_me = rd_alo && sel_ch == OWN_IDX;
            // clearing on read keeps an edge of the same cycle
            wire logic [CNT_W-1:0] base = (rd_me && ccfg_ff.mode == MODE_CLR_RD) ? '0 : cnt_ff;
            wire logic latch_ev = ccfg_ff.latch_map ? map_rise : scan_tick;

            logic [CNT_W-1:0] nxt_cnt;
            always_comb
            begin
                nxt_cnt = base;
                if (scan_begin)
                    nxt_cnt = '0;
                else if (up && !dn)
                    nxt_cnt = base + 1'b1;
                else if (dn && !up)
                    nxt_cnt = base - 1'b1;
            end

            wire logic [CNT_W-1:0] nxt_ahold = rd_me ? cnt_ff : ahold_ff;
            wire logic [CNT_W-1:0] nxt_shold = latch_ev ? cnt_ff : shold_ff;

            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    ccfg_ff <= CCFG_RST;
                    icfg_ff <= ICFG_RST;
                    cnt_ff <= '0;
                    ahold_ff <= '0;
                    shold_ff <= '0;
                end
                else
                begin
                    if (wr_ccfg && sel_ch == OWN_IDX)
                        ccfg_ff <= dec_ccfg_s'(bus.wdata[7:0]);
                    if (wr_icfg && sel_ch == OWN_IDX)
                        icfg_ff <= dec_icfg_s'(bus.wdata[6:0]);
                    cnt_ff <= nxt_cnt;
                    ahold_ff <= nxt_ahold;
                    shold_ff <= nxt_shold;
                end
            end

            assign ccfg_v[gi] = ccfg_ff;
            assign icfg_v[gi] = icfg_ff;
            assign cnt_v[gi] = cnt_ff;
            assign ahold_v[gi] = ahold_ff;
            assign shold_v[gi] = shold_ff;
        end
    endgenerate

    // ==========================================================
    // read data, valid only in the cycle after the read strobe
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd;

    always_comb
    begin
        nxt_rd = '0;
        if (bus.rd)
        begin
            case (sel_reg)
                REG_CFG_CNT: nxt_rd = {8'h00, ccfg_v[sel_ch]};
                REG_CFG_IN: nxt_rd = {9'h000, icfg_v[sel_ch]};
                REG_ASYNC_LO: nxt_rd = cnt_v[sel_ch][HALF_W-1:0];
                REG_ASYNC_HI: nxt_rd = ahold_v[sel_ch][CNT_W-1:HALF_W];
                REG_HOLD_LO: nxt_rd = shold_v[sel_ch][HALF_W-1:0];
                REG_HOLD_HI: nxt_rd = shold_v[sel_ch][CNT_W-1:HALF_W];
                default: nxt_rd = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_data_ff <= '0;
        else
            rd_data_ff <= nxt_rd;
    end

    assign rd_data = rd_data_ff;

    // ==========================================================
    // scan sample port: one slot per word, full width takes two
    logic pend_ff;
    logic [HALF_W-1:0] smp_upper_ff;
    logic [DATA_W-1:0] smp_data_ff;
    logic smp_vld_ff;
    logic smp_hi_ff;

    wire logic smp_take = smp.req && !pend_ff;
    wire logic [CNT_W-1:0] smp_src = shold_v[smp.ch];
    wire logic [HALF_W-1:0] smp_word = smp.hi ? smp_src[CNT_W-1:HALF_W] : smp_src[HALF_W-1:0];

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pend_ff <= 1'b0;
            smp_upper_ff <= '0;
            smp_data_ff <= '0;
            smp_vld_ff <= 1'b0;
            smp_hi_ff <= 1'b0;
        end
        else if (smp_take)
        begin
            // upper half stored now so both slots belong to one latched value
            pend_ff <= smp.full;
            smp_upper_ff <= smp_src[CNT_W-1:HALF_W];
            smp_data_ff <= smp.full ? smp_src[HALF_W-1:0] : smp_word;
            smp_vld_ff <= 1'b1;
            smp_hi_ff <= smp.hi && !smp.full;
        end
        else if (pend_ff)
        begin
            pend_ff <= 1'b0;
            smp_data_ff <= smp_upper_ff;
            smp_vld_ff <= 1'b1;
            smp_hi_ff <= 1'b1;
        end
        else
        begin
            smp_vld_ff <= 1'b0;
            smp_hi_ff <= 1'b0;
        end
    end

    assign smp_data = smp_data_ff;
    assign smp_vld = smp_vld_ff;
    assign smp_word_hi = smp_hi_ff;

endmodule

// ===== dec_pulse_src.sv
// partner model: pulse sources on the four counter pins
`timescale 1ns/1ps
module dec_pulse_src (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [19:0] cmd,
    output logic [3:0] pins,
    output logic busy
);
    // ====================
    // cmd is {mask, count, width, held level}; width 7 or more stays under 20 MHz
    logic [3:0] pul = 4'h0;
    assign pins = pul | cmd[3:0];
    initial busy = 1'b0;
    always
    begin
        @(posedge clk_sys);
        if (go)
        begin
            busy = 1'b1;
            repeat (cmd[15:8])
            begin
                pul <= cmd[19:16];
                repeat (cmd[7:4]) @(posedge clk_sys);
                pul <= 4'h0;
                repeat (cmd[7:4]) @(posedge clk_sys);
            end
            busy = 1'b0;
        end
    end
endmodule

// ===== dec_event_counter_monitor.sv
// checker: timing of the register and sample ports
`timescale 1ns/1ps
module dec_event_counter_monitor
    import dec_pkg::*;
#(
    parameter int DBNC_TICK_CYC_P = DBNC_TICK_CYC
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NUM_CH-1:0] cnt_pin,
    input wire logic scan_begin,
    input wire logic scan_tick,
    input wire dec_bus_s bus,
    input wire logic [DATA_W-1:0] rd_data,
    input wire dec_smp_s smp,
    input wire logic [DATA_W-1:0] smp_data,
    input wire logic smp_vld,
    input wire logic smp_word_hi
);
    // ====================
    // second word of a full sample still owed
    logic full2_ff;
    logic nxt_full2;
    logic rd_lo;
    assign nxt_full2 = smp.req && smp.full && !full2_ff;
    assign rd_lo = bus.rd && bus.addr[2:0] == REG_ASYNC_LO;
    always_ff @(posedge clk_sys)
    begin
        full2_ff <= sys_rst ? 1'b0 : nxt_full2;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ====================
    // assertions
    rd_idle_zero_a: assert property (!$past(bus.rd) |-> rd_data == 16'h0000)
        else $error("read data not idle");
    scan_clear_a: assert property (scan_begin ##1 rd_lo |=> rd_data == 16'h0000)
        else $error("count not cleared");
    smp_answer_a: assert property (smp.req |=> smp_vld)
        else $error("sample not answered");
    smp_pair_a: assert property (nxt_full2 |=> smp_vld && !smp_word_hi ##1 smp_vld && smp_word_hi)
        else $error("full sample order");
    smp_single_a: assert property (smp.req && !smp.full && !full2_ff |=> smp_word_hi == $past(smp.hi))
        else $error("single word half");
    smp_cause_a: assert property (smp_vld |-> $past(smp.req) || $past(full2_ff))
        else $error("word without request");
    hi_idle_a: assert property (!smp_vld |-> !smp_word_hi)
        else $error("half flag while idle");
    smp_hold_a: assert property (!smp_vld && !$past(sys_rst) |-> $stable(smp_data))
        else $error("sample data moved");
    cover property (nxt_full2 ##1 smp.req);
    cover property (scan_begin ##1 rd_lo);
    cover property (scan_tick);
endmodule
bind dec_event_counter dec_event_counter_monitor #(.DBNC_TICK_CYC_P(DBNC_TICK_CYC_P)) mon_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .cnt_pin(cnt_pin), .scan_begin(scan_begin), .scan_tick(scan_tick), .bus(bus),
    .rd_data(rd_data), .smp(smp), .smp_data(smp_data), .smp_vld(smp_vld), .smp_word_hi(smp_word_hi));

// ===== debounced_event_counter_tb_top.sv
// testbench: register, sample port and pin scenarios
`timescale 1ns/1ps
module debounced_event_counter_tb_top;
    import dec_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, scan_begin = 1'b0, scan_tick = 1'b0, go = 1'b0;
    logic busy, smp_vld, smp_word_hi;
    logic [3:0] cnt_pin;
    logic [19:0] cmd = '0;
    logic [DATA_W-1:0] rd_data, smp_data;
    dec_bus_s bus = '0;
    dec_smp_s smp = '0;
    int err_count = 0;
    int cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    dec_event_counter #(.DBNC_TICK_CYC_P(2)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .cnt_pin(cnt_pin),
        .scan_begin(scan_begin), .scan_tick(scan_tick), .bus(bus), .rd_data(rd_data), .smp(smp),
        .smp_data(smp_data), .smp_vld(smp_vld), .smp_word_hi(smp_word_hi));
    dec_pulse_src src_u (.clk_sys(clk_sys), .go(go), .cmd(cmd), .pins(cnt_pin), .busy(busy));
    // ====================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        bus <= {1'b1, 1'b0, a, v};
        @(posedge clk_sys);
        bus <= '0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        bus <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_sys);
        bus <= '0;
        #1 chk(rd_data, exp);
    endtask
    task automatic pl(input logic [3:0] m, input logic [7:0] k, input logic [3:0] wd, input logic [3:0] h);
        @(posedge clk_sys);
        cmd <= {m, k, wd, h};
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        #1;
        repeat (3000) if (busy) @(posedge clk_sys);
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic sc(input logic [1:0] v);
        @(posedge clk_sys);
        {scan_begin, scan_tick} <= v;
        @(posedge clk_sys);
        {scan_begin, scan_tick} <= 2'b00;
    endtask
    task end_sim;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_sim;
    end
    // ====================
    // scenarios
    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        sc(2'b10);
        pl(4'h1, 8'd5, 4'h8, 4'h0);
        rd(5'h02, 16'h0005);
        rd(5'h03, 16'h0000);
        sc(2'b01);
        rd(5'h04, 16'h0005);
        pl(4'h1, 8'd3, 4'h8, 4'h0);
        rd(5'h02, 16'h0008);
        rd(5'h06, 16'h0000);
        wr(5'h00, 16'h0001);
        rd(5'h02, 16'h0008);
        rd(5'h02, 16'h0000);
        wr(5'h00, 16'h0060);
        pl(4'h2, 8'd1, 4'h8, 4'h0);
        rd(5'h02, 16'hFFFF);
        rd(5'h03, 16'hFFFF);
        wr(5'h00, 16'h0006);
        pl(4'h1, 8'd2, 4'h8, 4'h0);
        rd(5'h02, 16'hFFFF);
        wr(5'h00, 16'h0002);
        pl(4'h1, 8'd1, 4'h8, 4'h0);
        rd(5'h03, 16'hFFFF);
        wr(5'h00, 16'h0000);
        pl(4'h1, 8'd1, 4'h8, 4'h0);
        rd(5'h02, 16'h0000);
        rd(5'h03, 16'h0000);
        sc(2'b10);
        wr(5'h00, 16'h0050);
        pl(4'h1, 8'd3, 4'h8, 4'h0);
        rd(5'h02, 16'h0000);
        pl(4'h0, 8'd0, 4'h8, 4'h2);
        pl(4'h1, 8'd3, 4'h8, 4'h2);
        rd(5'h02, 16'h0003);
        wr(5'h00, 16'h0048);
        pl(4'h1, 8'd4, 4'h8, 4'h0);
        sc(2'b01);
        rd(5'h04, 16'h0005);
        pl(4'h2, 8'd1, 4'h8, 4'h0);
        rd(5'h04, 16'h0007);
        @(posedge clk_sys);
        scan_begin <= 1'b1;
        @(posedge clk_sys);
        scan_begin <= 1'b0;
        bus <= {1'b0, 1'b1, 5'h02, 16'h0000};
        @(posedge clk_sys);
        bus <= '0;
        smp <= {1'b1, 2'd0, 1'b1, 1'b0};
        #1 chk(rd_data, 16'h0000);
        @(posedge clk_sys);
        smp <= {1'b1, 2'd0, 1'b0, 1'b1};
        #1 chk({smp_word_hi, smp_vld, smp_data[13:0]}, 16'h4007);
        @(posedge clk_sys);
        smp <= {1'b1, 2'd0, 1'b0, 1'b1};
        #1 chk({smp_word_hi, smp_vld, smp_data[13:0]}, 16'hC000);
        @(posedge clk_sys);
        smp <= '0;
        #1 chk({smp_word_hi, smp_vld, smp_data[13:0]}, 16'hC000);
        wr(5'h19, 16'h0001);
        pl(4'h0, 8'd0, 4'h8, 4'h0);
        sc(2'b10);
        pl(4'h0, 8'd0, 4'h8, 4'h8);
        rd(5'h1A, 16'h0000);
        pl(4'h0, 8'd0, 4'h8, 4'h0);
        rd(5'h1A, 16'h0001);
        wr(5'h11, 16'h000A);
        pl(4'h0, 8'd0, 4'h8, 4'h0);
        sc(2'b10);
        pl(4'h4, 8'd3, 4'h2, 4'h0);
        rd(5'h12, 16'h0000);
        pl(4'h4, 8'd2, 4'h8, 4'h0);
        rd(5'h12, 16'h0002);
        wr(5'h11, 16'h000C);
        pl(4'h0, 8'd0, 4'h8, 4'h0);
        sc(2'b10);
        pl(4'h4, 8'd3, 4'h2, 4'h0);
        rd(5'h12, 16'h0001);
        end_sim;
    end
endmodule
